// *** alsenc_regs.vh ***
`ifndef ALSENC_REGS_VH
`define ALSENC_REGS_VH
// =====================================================================
// register map (word offsets are byte addresses)
`define ALSENC_ADDR_W 4
`define ALSENC_REG_COND 4'h0
`define ALSENC_REG_CTRL 4'h4
`define ALSENC_REG_STAT 4'h8
`define ALSENC_REG_ADDR 4'hc
// =====================================================================
// condition register bits
`define ALSENC_C_AC_PRESENT 0
`define ALSENC_C_AC_OUTLIM 1
`define ALSENC_C_THERM_WARN 2
`define ALSENC_C_THERM_SHDN 3
`define ALSENC_C_FUSE 4
`define ALSENC_C_BOOST 5
`define ALSENC_C_OV_LATCH 6
`define ALSENC_C_OVERLOAD 7
`define ALSENC_C_INT_FAIL 8
`define ALSENC_C_STANDBY 9
`define ALSENC_C_SVC_REQ 10
`define ALSENC_C_COMM_FLT 11
`define ALSENC_COND_W 12
`define ALSENC_COND_RST 12'h000
// ctrl bit: output enable request from software
`define ALSENC_CTRL_OUT_EN 0
// =====================================================================
// timing
`define ALSENC_CLK_HZ 200000000
`define ALSENC_MS_PER_S 1000
`define ALSENC_US_PER_S 1000000
`define ALSENC_PG_PERIOD_US 1000
`define ALSENC_BLINK_MS 500
`endif

// *** alsenc_top.v ***
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
`include "alsenc_regs.vh"

// What this block does
// - in thermal alarm the service led is lit and overtemp warning low, rest ok.
// - overtemp warning is high normally and low from 5C below shutdown.
// - fuse or boost failure lights ac and fault leds and pulls fault, pg low.
// - latched overvoltage acts like rule three with overtemp warning high.
// - ac out of limits blinks ac led, pulls pg low; no ac turns ac led off.
// - overload blinks dc led and pulses pg with a 1 ms period.
// - a non-shutdown internal failure lights fault led and pulls fault low.
// - in pmbus mode a service request blinks the service led.
// - in rs485 mode a comm fault blinks the fault led.
// - fault alarm is open drain: released high, pulled low on a fault.
// - pg warning is low when loss of output is imminent, else released.
// - protocol input open selects pmbus, resistor fitted selects rs485.
// - address bits a3..a0 come from the first then second address level.
module alsenc_top #(
    parameter CLK_HZ = `ALSENC_CLK_HZ,
    parameter BLINK_MS = `ALSENC_BLINK_MS,
    parameter PG_PERIOD_US = `ALSENC_PG_PERIOD_US,
    parameter LVL_W = 2
) (
    input wire CLK_I,
    input wire RST_I,
    input wire [`ALSENC_ADDR_W-1:0] AVS_ADDRESS_I,
    input wire AVS_READ_I,
    input wire AVS_WRITE_I,
    input wire [31:0] AVS_WRITEDATA_I,
    input wire [3:0] AVS_BYTEENABLE_I,
    output reg [31:0] AVS_READDATA_O,
    output wire AVS_WAITREQUEST_O,
    input wire ON_OFF_N_I,
    input wire PROTOCOL_RES_I,
    input wire [LVL_W-1:0] ADDR_LEVEL_FIRST_I,
    input wire [LVL_W-1:0] ADDR_LEVEL_SECOND_I,
    output reg LED_AC_O,
    output reg LED_DC_O,
    output reg LED_SERVICE_O,
    output reg LED_FAULT_O,
    output wire FAULT_N_O,
    output wire FAULT_N_OE_N_O,
    output wire OVERTEMP_WARN_N_O,
    output wire OVERTEMP_WARN_N_OE_N_O,
    output wire POWER_GOOD_WARN_N_O,
    output wire POWER_GOOD_WARN_N_OE_N_O,
    output wire MODULE_PRESENT_N_O,
    output reg MAIN_OUT_EN_O,
    output reg RS485_MODE_O,
    output reg [2*LVL_W-1:0] ADDR_BITS_O
);

// =====================================================================
// timing counts
// integer division: clk_hz should be a whole number of mhz, else the
// pg period comes out short; the blink period needs only whole khz
localparam integer CYC_PER_MS = CLK_HZ / `ALSENC_MS_PER_S;
localparam integer CYC_PER_US = CLK_HZ / `ALSENC_US_PER_S;
localparam integer BLINK_HALF = CYC_PER_MS * BLINK_MS;
localparam integer PG_HALF = CYC_PER_US * PG_PERIOD_US / 2;
localparam integer N_ALARM = 3;

// =====================================================================
// register bus: one wait cycle, then the answer
// every access takes two cycles: waitrequest is high in the first, the
// second commits a write or presents read data; ack_q drops right after
// so back to back requests each see their own wait cycle
reg ack_q;
reg [`ALSENC_COND_W-1:0] cond_q;
reg ctrl_out_en_q;
wire req = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
wire wr_now = AVS_WRITE_I & ack_q;
wire rd_now = AVS_READ_I & ack_q;
assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;

always @(posedge CLK_I) begin
    if (RST_I) begin
        ack_q <= 1'b0;
    end else begin
        ack_q <= req;
    end
end

always @(posedge CLK_I) begin
    if (RST_I) begin
        cond_q <= `ALSENC_COND_RST;
        ctrl_out_en_q <= 1'b0;
    end else if (wr_now) begin
        // stat and addr are read only; writes there and to unmapped
        // addresses are dropped
        if (AVS_ADDRESS_I == `ALSENC_REG_COND) begin
            // only lanes 0 and 1 carry condition bits
            if (AVS_BYTEENABLE_I[0])
                cond_q[7:0] <= AVS_WRITEDATA_I[7:0];
            if (AVS_BYTEENABLE_I[1])
                cond_q[`ALSENC_COND_W-1:8] <=
                    AVS_WRITEDATA_I[`ALSENC_COND_W-1:8];
        end
        if (AVS_ADDRESS_I == `ALSENC_REG_CTRL && AVS_BYTEENABLE_I[0])
            ctrl_out_en_q <= AVS_WRITEDATA_I[`ALSENC_CTRL_OUT_EN];
    end
end

// =====================================================================
// blink and pg pulse timers
reg [31:0] blink_cnt_q;
reg blink_q;
reg [31:0] pg_cnt_q;
reg pg_pulse_q;
always @(posedge CLK_I) begin
    if (RST_I) begin
        blink_cnt_q <= 32'h0;
        blink_q <= 1'b0;
        pg_cnt_q <= 32'h0;
        pg_pulse_q <= 1'b1;
    end else begin
        // one shared slow phase keeps all blinking leds in step
        if (blink_cnt_q >= BLINK_HALF - 1) begin
            blink_cnt_q <= 32'h0;
            blink_q <= ~blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h1;
        end
        // pg pulse restarts high on each overload so the first half
        // period is always a released level
        if (!cond_q[`ALSENC_C_OVERLOAD]) begin
            pg_cnt_q <= 32'h0;
            pg_pulse_q <= 1'b1;
        end else if (pg_cnt_q >= PG_HALF - 1) begin
            pg_cnt_q <= 32'h0;
            pg_pulse_q <= ~pg_pulse_q;
        end else begin
            pg_cnt_q <= pg_cnt_q + 32'h1;
        end
    end
end

// =====================================================================
// priority encoder, most severe first
// severity order, highest first: thermal shutdown, latched overvoltage,
// fuse or boost failure, ac absent, ac out of limits, standby, overload,
// internal failure, thermal warning, service request, comm fault.
// only the top active condition drives the pins; a lower one shows again
// as soon as software clears the ones above it
reg ac_d, dc_d, svc_d, flt_d, fault_d, otw_d, pg_d;
wire pmbus = ~PROTOCOL_RES_I;
always @* begin
    ac_d = 1'b1;
    dc_d = 1'b1;
    svc_d = 1'b0;
    flt_d = 1'b0;
    fault_d = 1'b1;
    otw_d = 1'b1;
    pg_d = 1'b1;
    if (cond_q[`ALSENC_C_THERM_SHDN]) begin
        dc_d = 1'b0;
        svc_d = 1'b1;
        flt_d = 1'b1;
        fault_d = 1'b0;
        otw_d = 1'b0;
        pg_d = 1'b0;
    end else if (cond_q[`ALSENC_C_OV_LATCH]) begin
        dc_d = 1'b0;
        flt_d = 1'b1;
        fault_d = 1'b0;
        pg_d = 1'b0;
    end else if (cond_q[`ALSENC_C_FUSE] | cond_q[`ALSENC_C_BOOST]) begin
        dc_d = 1'b0;
        flt_d = 1'b1;
        fault_d = 1'b0;
        pg_d = 1'b0;
    end else if (!cond_q[`ALSENC_C_AC_PRESENT]) begin
        ac_d = 1'b0;
        dc_d = 1'b0;
        pg_d = 1'b0;
    end else if (cond_q[`ALSENC_C_AC_OUTLIM]) begin
        ac_d = blink_q;
        dc_d = 1'b0;
        pg_d = 1'b0;
    end else if (cond_q[`ALSENC_C_STANDBY]) begin
        // remote standby: output off while the input is still fine
        dc_d = 1'b0;
        pg_d = 1'b0;
    end else if (cond_q[`ALSENC_C_OVERLOAD]) begin
        // pg pulses instead of holding low: load is carried but at risk
        dc_d = blink_q;
        pg_d = pg_pulse_q;
    end else if (cond_q[`ALSENC_C_INT_FAIL]) begin
        // unit keeps running, so dc and pg stay good
        flt_d = 1'b1;
        fault_d = 1'b0;
    end else if (cond_q[`ALSENC_C_THERM_WARN]) begin
        svc_d = 1'b1;
        otw_d = 1'b0;
        // mode gated: a blink means something else in each protocol
    end else if (pmbus & cond_q[`ALSENC_C_SVC_REQ]) begin
        svc_d = blink_q;
    end else if (!pmbus & cond_q[`ALSENC_C_COMM_FLT]) begin
        flt_d = blink_q;
    end
end

// =====================================================================
// output flops
// all pins change on one edge, so a shelf controller never sees a
// mixture of old and new alarm states
reg fault_q, otw_q, pg_q;
always @(posedge CLK_I) begin
    if (RST_I) begin
        LED_AC_O <= 1'b0;
        LED_DC_O <= 1'b0;
        LED_SERVICE_O <= 1'b0;
        LED_FAULT_O <= 1'b0;
        fault_q <= 1'b1;
        otw_q <= 1'b1;
        pg_q <= 1'b1;
    end else begin
        LED_AC_O <= ac_d;
        LED_DC_O <= dc_d;
        LED_SERVICE_O <= svc_d;
        LED_FAULT_O <= flt_d;
        fault_q <= fault_d;
        otw_q <= otw_d;
        pg_q <= pg_d;
    end
end

// =====================================================================
// mode, output enable and address levels
always @(posedge CLK_I) begin
    if (RST_I) begin
        MAIN_OUT_EN_O <= 1'b0;
        RS485_MODE_O <= 1'b0;
        ADDR_BITS_O <= {2*LVL_W{1'b0}};
    end else begin
        // on/off only gates the output in pmbus/analog mode
        MAIN_OUT_EN_O <= ctrl_out_en_q &
            (~pmbus | ~ON_OFF_N_I);
        RS485_MODE_O <= ~pmbus;
        // upper address bits from the first level, lower from the second
        ADDR_BITS_O <= {ADDR_LEVEL_FIRST_I, ADDR_LEVEL_SECOND_I};
    end
end

// =====================================================================
// alarm pins
// open drain: drive low only, enable active low while driving;
// the pad never drives high, so a released pin rests at the pull-up
wire [N_ALARM-1:0] alarm_q = {pg_q, otw_q, fault_q};
wire [N_ALARM-1:0] od_data;
wire [N_ALARM-1:0] od_oe_n;
genvar gi;
generate
    for (gi = 0; gi < N_ALARM; gi = gi + 1) begin : g_od
        assign od_data[gi] = 1'b0;
        assign od_oe_n[gi] = alarm_q[gi];
    end
endgenerate
assign FAULT_N_O = od_data[0];
assign FAULT_N_OE_N_O = od_oe_n[0];
assign OVERTEMP_WARN_N_O = od_data[1];
assign OVERTEMP_WARN_N_OE_N_O = od_oe_n[1];
assign POWER_GOOD_WARN_N_O = od_data[2];
assign POWER_GOOD_WARN_N_OE_N_O = od_oe_n[2];
// module present is a short pin: pulled low whenever the unit is seated
assign MODULE_PRESENT_N_O = 1'b0;

// =====================================================================
// status snapshot for software
wire [31:0] stat_word = {21'h0, MAIN_OUT_EN_O, RS485_MODE_O,
    pg_q, otw_q, fault_q, LED_FAULT_O, LED_SERVICE_O,
    LED_DC_O, LED_AC_O, blink_q, pg_pulse_q};

// =====================================================================
// read mux
always @(posedge CLK_I) begin
    if (RST_I) begin
        AVS_READDATA_O <= 32'h0;
    end else if (req & AVS_READ_I) begin
        case (AVS_ADDRESS_I)
            `ALSENC_REG_COND:
                AVS_READDATA_O <= {{(32-`ALSENC_COND_W){1'b0}}, cond_q};
            `ALSENC_REG_CTRL:
                AVS_READDATA_O <= {31'h0, ctrl_out_en_q};
            `ALSENC_REG_STAT:
                AVS_READDATA_O <= stat_word;
            `ALSENC_REG_ADDR:
                AVS_READDATA_O <= {{(32-2*LVL_W){1'b0}}, ADDR_BITS_O};
            default:
                AVS_READDATA_O <= 32'h0;
        endcase
    end
end

endmodule // alsenc_top

// *** alsenc_top_monitor.sv ***
`timescale 1ns/10ps
module alsenc_top_monitor #(
    parameter LVL_W = 2
) (
    input wire CLK_I,
    input wire RST_I,
    input wire AVS_READ_I,
    input wire AVS_WRITE_I,
    input wire AVS_WAITREQUEST_O,
    input wire ON_OFF_N_I,
    input wire PROTOCOL_RES_I,
    input wire [LVL_W-1:0] ADDR_LEVEL_FIRST_I,
    input wire [LVL_W-1:0] ADDR_LEVEL_SECOND_I,
    input wire LED_AC_O,
    input wire LED_SERVICE_O,
    input wire LED_FAULT_O,
    input wire FAULT_N_O,
    input wire FAULT_N_OE_N_O,
    input wire OVERTEMP_WARN_N_O,
    input wire OVERTEMP_WARN_N_OE_N_O,
    input wire POWER_GOOD_WARN_N_O,
    input wire POWER_GOOD_WARN_N_OE_N_O,
    input wire MAIN_OUT_EN_O,
    input wire RS485_MODE_O,
    input wire [2*LVL_W-1:0] ADDR_BITS_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // =====================================================
    // alarm pins and leds
    // open drain: the data side may never drive high
    property p_od; !FAULT_N_O && !OVERTEMP_WARN_N_O && !POWER_GOOD_WARN_N_O;
    endproperty
    a_od: assert property (p_od) else $error("alarm data high");
    property p_flt; !FAULT_N_OE_N_O |-> LED_FAULT_O; endproperty
    a_flt: assert property (p_flt) else $error("fault led off");
    property p_otw; !OVERTEMP_WARN_N_OE_N_O |-> LED_SERVICE_O; endproperty
    a_otw: assert property (p_otw) else $error("service led off");
    // first cycle after reset still shows reset values
    property p_pg; !LED_AC_O && !$past(RST_I) |-> !POWER_GOOD_WARN_N_OE_N_O;
    endproperty
    a_pg: assert property (p_pg) else $error("pg released");
    // =====================================================
    // control inputs and bus
    property p_en; ON_OFF_N_I && !PROTOCOL_RES_I |=> !MAIN_OUT_EN_O;
    endproperty
    a_en: assert property (p_en) else $error("output on");
    property p_md; 1 |=> RS485_MODE_O == $past(PROTOCOL_RES_I); endproperty
    a_md: assert property (p_md) else $error("mode wrong");
    property p_ad; 1 |=> ADDR_BITS_O ==
        {$past(ADDR_LEVEL_FIRST_I), $past(ADDR_LEVEL_SECOND_I)}; endproperty
    a_ad: assert property (p_ad) else $error("addr bits wrong");
    property p_wq; (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
        |=> !AVS_WAITREQUEST_O; endproperty
    a_wq: assert property (p_wq) else $error("wait too long");
endmodule // alsenc_top_monitor
bind alsenc_top alsenc_top_monitor #(.LVL_W(LVL_W)) u_mon (.*);

// *** alsenc_ctrl_model.sv ***
`timescale 1ns/10ps
// shelf controller: pull-ups hold each alarm high while released
module alsenc_ctrl_model (
    input wire f_oe_n_i,
    input wire o_oe_n_i,
    input wire p_oe_n_i,
    output wire fault_n_o,
    output wire otw_n_o,
    output wire pg_n_o
);
    assign fault_n_o = f_oe_n_i ? 1'b1 : 1'b0;
    assign otw_n_o = o_oe_n_i ? 1'b1 : 1'b0;
    assign pg_n_o = p_oe_n_i ? 1'b1 : 1'b0;
endmodule // alsenc_ctrl_model

// *** alsenc_top_bench.sv ***
`timescale 1ns/10ps
`include "alsenc_regs.vh"
module alsenc_top_bench;
    localparam int BH = 2000;
    localparam int PH = 4;
    logic CLK_I = 1'b0;
    logic RST_I = 1'b1;
    logic [3:0] AVS_ADDRESS_I = 4'h0;
    logic AVS_READ_I = 1'b0;
    logic AVS_WRITE_I = 1'b0;
    logic [31:0] AVS_WRITEDATA_I = 32'h0;
    logic [3:0] AVS_BYTEENABLE_I = 4'hf;
    logic ON_OFF_N_I = 1'b1;
    logic PROTOCOL_RES_I = 1'b0;
    logic [1:0] ADDR_LEVEL_FIRST_I = 2'h0;
    logic [1:0] ADDR_LEVEL_SECOND_I = 2'h0;
    wire [31:0] AVS_READDATA_O;
    wire [3:0] ADDR_BITS_O;
    wire AVS_WAITREQUEST_O, LED_AC_O, LED_DC_O, LED_SERVICE_O, LED_FAULT_O,
        FAULT_N_O, FAULT_N_OE_N_O, OVERTEMP_WARN_N_O, OVERTEMP_WARN_N_OE_N_O,
        POWER_GOOD_WARN_N_O, POWER_GOOD_WARN_N_OE_N_O, MODULE_PRESENT_N_O,
        MAIN_OUT_EN_O, RS485_MODE_O, fault_n, otw_n, pg_n;
    wire [6:0] st = {LED_AC_O, LED_DC_O, LED_SERVICE_O, LED_FAULT_O,
        fault_n, otw_n, pg_n};
    logic [11:0] tc [15] = '{12'h001, 12'h005, 12'h009, 12'h011, 12'h021,
        12'h041, 12'h101, 12'h000, 12'h015, 12'h003, 12'h081, 12'h081,
        12'h401, 12'h801, 12'h201};
    logic [6:0] te [15] = '{7'h67, 7'h75, 7'h58, 7'h48, 7'h48, 7'h4a, 7'h69,
        7'h04, 7'h48, 7'h04, 7'h46, 7'h46, 7'h67, 7'h67, 7'h44};
    logic [6:0] tm [15] = '{7'h7f, 7'h7f, 7'h7f, 7'h7d, 7'h7d, 7'h7f, 7'h7d,
        7'h7d, 7'h7d, 7'h3d, 7'h5e, 7'h5e, 7'h6f, 7'h77, 7'h7d};
    int ts [15] = '{7, 7, 7, 7, 7, 7, 7, 7, 7, 6, 5, 0, 4, 3, 7};
    int n_errors = 0;
    int total_checks = 0;
    logic [31:0] q;
    always #2.5 CLK_I = ~CLK_I;
    // short counts: blink half 2000 cycles, pg half 4 cycles
    alsenc_top #(.CLK_HZ(2000000), .BLINK_MS(1), .PG_PERIOD_US(4)) uut (.*);
    alsenc_ctrl_model u_ctrl (.f_oe_n_i(FAULT_N_OE_N_O),
        .o_oe_n_i(OVERTEMP_WARN_N_OE_N_O), .p_oe_n_i(POWER_GOOD_WARN_N_OE_N_O),
        .fault_n_o(fault_n), .otw_n_o(otw_n), .pg_n_o(pg_n));
    // =====================================================
    // shared tasks
    task chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
        total_checks++;
        if (got !== ex) begin
            n_errors++;
            $display("[FAIL] %s exp %h got %h", nm, ex, got);
        end
    endtask
    // waitrequest and read data are read at the rising edge itself,
    // before the design's own updates for that edge land
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK_I);
        AVS_ADDRESS_I <= a;
        AVS_WRITEDATA_I <= d;
        AVS_WRITE_I <= w;
        AVS_READ_I <= !w;
        @(posedge CLK_I);
        while (AVS_WAITREQUEST_O !== 1'b0) @(posedge CLK_I);
        q = AVS_READDATA_O;
        AVS_WRITE_I <= 1'b0;
        AVS_READ_I <= 1'b0;
    endtask
    task gap(input int s, output logic [31:0] n);
        logic v;
        int k;
        v = st[s];
        k = 0;
        while (st[s] === v && k < 3 * BH) begin
            @(negedge CLK_I);
            k++;
        end
        v = st[s];
        n = 0;
        while (st[s] === v && n < 3 * BH) begin
            @(negedge CLK_I);
            n++;
        end
    endtask
    // =====================================================
    // scenarios
    task t_regs;
        bus(1'b1, `ALSENC_REG_COND, 32'h00000fff);
        bus(1'b1, 4'h2, 32'h00000001);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", q, 32'h0);
        bus(1'b0, `ALSENC_REG_COND, 32'h0);
        chk("cond", q, 32'h00000fff);
        $display("t_regs done");
    endtask
    task t_states;
        logic [31:0] g;
        for (int i = 0; i < 15; i++) begin
            @(posedge CLK_I);
            PROTOCOL_RES_I <= tc[i][11];
            bus(1'b1, `ALSENC_REG_COND, {20'h0, tc[i]});
            repeat (3) @(negedge CLK_I);
            chk("state", st & tm[i], te[i] & tm[i]);
            if (ts[i] != 7) begin
                gap(ts[i], g);
                chk("half", g, (ts[i] == 0) ? PH : BH);
            end
        end
        $display("t_states done");
    endtask
    task t_ctrl;
        @(posedge CLK_I);
        PROTOCOL_RES_I <= 1'b0;
        ADDR_LEVEL_FIRST_I <= 2'h2;
        ADDR_LEVEL_SECOND_I <= 2'h1;
        bus(1'b1, `ALSENC_REG_CTRL, 32'h00000001);
        repeat (3) @(negedge CLK_I);
        chk("en_open", MAIN_OUT_EN_O, 1'b0);
        chk("addr", ADDR_BITS_O, 4'h9);
        chk("pmbus", RS485_MODE_O, 1'b0);
        chk("present", MODULE_PRESENT_N_O, 1'b0);
        bus(1'b0, `ALSENC_REG_CTRL, 32'h0);
        chk("ctrl", q, 32'h00000001);
        bus(1'b0, `ALSENC_REG_ADDR, 32'h0);
        chk("addr_reg", q, 32'h00000009);
        @(posedge CLK_I);
        ON_OFF_N_I <= 1'b0;
        repeat (3) @(negedge CLK_I);
        chk("en_short", MAIN_OUT_EN_O, 1'b1);
        @(posedge CLK_I);
        PROTOCOL_RES_I <= 1'b1;
        ON_OFF_N_I <= 1'b1;
        repeat (3) @(negedge CLK_I);
        chk("rs485", RS485_MODE_O, 1'b1);
        chk("en_rs485", MAIN_OUT_EN_O, 1'b1);
        $display("t_ctrl done");
    endtask
    task test_done;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge CLK_I);
        RST_I <= 1'b0;
        t_regs();
        t_states();
        t_ctrl();
        test_done();
    end
    initial begin
        #300000;
        n_errors++;
        test_done();
    end
endmodule // alsenc_top_bench
